// File: spc_pkg.sv
// package for the status protection control block: opcodes, status bit
// positions, protect modes and the packed carriers of both clock domains.
// assumes one serial link clock domain and one system clock domain.
package spc_pkg;

  // ===========================================================
  // command opcodes seen at the link
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OP_SUSPEND = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7A;
  localparam logic [7:0] OP_FOUR_WIRE_ON = 8'h38;
  localparam logic [7:0] OP_FOUR_WIRE_OFF = 8'hFF;
  localparam logic [7:0] OP_SEC_PROGRAM = 8'h42;
  localparam logic [7:0] OP_SEC_ERASE = 8'h44;

  // ===========================================================
  // status word bit positions
  localparam int BIT_SUSPEND = 15;
  localparam int BIT_LOCK_HI = 13;
  localparam int BIT_LOCK_LO = 10;
  localparam int BIT_QUAD = 9;
  localparam int BIT_PM_HI = 8;
  localparam int BIT_PM_LO = 7;
  localparam int LOCK_W = 4;

  // ===========================================================
  // protect modes, as {protect_mode_hi, protect_mode_lo}
  localparam logic [1:0] PM_SOFTWARE = 2'h0;
  localparam logic [1:0] PM_HARDWARE = 2'h1;
  localparam logic [1:0] PM_LOCKDOWN = 2'h2;
  localparam logic [1:0] PM_ONE_TIME = 2'h3;

  // reset value of the lock bits, held until the stored image loads
  localparam logic [LOCK_W-1:0] LOCK_NONE = 4'h0;

  // ===========================================================
  // carriers
  typedef struct packed {
    logic [7:0] opcode;
    logic [15:0] data;
    logic [1:0] sec_sel;
  } cmd_t;

  typedef struct packed {
    logic [LOCK_W-1:0] secure_lock_bits;
    logic quad_enable;
    logic protect_mode_hi;
    logic protect_mode_lo;
  } nv_t;

  typedef struct packed {
    logic suspend_flag;
    nv_t nv;
  } ctl_bits_t;

  typedef enum logic [1:0] {
    PWR_OFF = 2'b00,
    PWR_LOAD = 2'b01,
    PWR_RUN = 2'b10
  } pwr_state_t;

  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic tog;
    cmd_t cmd;
  } link_state_t;

  typedef struct packed {
    pwr_state_t pwr;
    logic tog_s1;
    logic tog_s2;
    logic tog_s3;
    logic wp_s1;
    logic wp_s2;
    logic hold_s1;
    logic hold_s2;
    ctl_bits_t ctl;
    logic write_enable_latch;
    logic four_wire;
    logic ready;
    logic wp_func;
    logic hold_func;
    logic hold_held;
    logic wsr_done;
    logic wsr_refused;
    logic sec_grant;
    logic sec_refused;
    logic cmd_ignored;
  } core_state_t;

endpackage

// File: status_protection_control.sv
// status protection control: write protection modes, suspend flag,
// security register locks and quad enable of a serial flash.
// assumes a command decoder on the serial clock that strobes each finished
// command once, and a non-volatile store that presents its image at power-up.
//
// Notes on behaviour
// RULE_01: protect mode 0,1 with write protect high: status write needs latch.
// RULE_02: protect mode 1,0 refuses every status write until power cycle.
// RULE_03: power cycle turns protect mode 1,0 back into 0,0.
// RULE_04: protect mode 1,1 refuses status writes forever, pin ignored.
// RULE_05: suspend opcode 75h sets the read-only suspend flag, bit 15.
// RULE_06: resume opcode 7Ah or a power cycle clears the suspend flag.
// RULE_07: four lock bits at bits 13..10 start at zero, all unlocked.
// RULE_08: lock bits are set one by one by status write, never cleared.
// RULE_09: a locked security register refuses program and erase forever.
// RULE_10: quad enable at bit 9 defaults zero; then pin functions stay active.
// RULE_11: quad enable one turns protect and hold pins into data lines.
// RULE_12: four-wire mode entry 38h is ignored while quad enable is zero.
// RULE_13: in four-wire mode quad enable stays one; writes cannot clear it.
// RULE_14: host should not set quad enable with pins tied to rails.
// RULE_15: protect mode bits sit at bits 8 and 7, read and write.
// RULE_16: protect mode 0,0 ignores the pin; status write needs the latch.
// RULE_17: protect mode 0,1 with write protect low locks the status bits.
// RULE_18: a refused status write changes no status bit at all.
module status_protection_control
  import spc_pkg::*;
(
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic sclk_i,
  input wire logic cmd_strobe_i,
  input wire cmd_t cmd_i,
  input wire logic write_protect_n_i,
  input wire logic hold_n_i,
  input wire nv_t nv_image_i,
  output logic ready_o,
  output ctl_bits_t ctl_o,
  output logic write_enable_latch_o,
  output logic four_wire_command_mode_o,
  output logic wp_function_o,
  output logic hold_function_o,
  output logic hold_asserted_o,
  output logic wsr_done_o,
  output logic wsr_refused_o,
  output logic sec_grant_o,
  output logic sec_refused_o,
  output logic cmd_ignored_o
);

  // ===========================================================
  // link domain: capture each finished command and flip a toggle
  link_state_t lq;
  link_state_t next_lq;

  // reset is brought in by two flops; the command is held until the next
  // strobe so the system side may read it after seeing the toggle move
  always_comb begin
    next_lq = lq;
    next_lq.rst_s1 = srst_i;
    next_lq.rst_s2 = lq.rst_s1;
    if (lq.rst_s2) begin
      next_lq.tog = 1'b0;
      next_lq.cmd = '0;
    end else if (cmd_strobe_i) begin
      next_lq.tog = ~lq.tog;
      next_lq.cmd = cmd_i;
    end
  end

  always_ff @(posedge sclk_i) begin
    lq <= next_lq;
  end

  // ===========================================================
  // system domain
  core_state_t q;
  core_state_t next_q;

  logic cmd_go;
  logic wp_eff;
  logic [1:0] pm;
  logic wsr_allowed;
  logic [LOCK_W-1:0] new_locks;
  logic new_quad;
  logic sec_locked;

  // decode of the current command against the current state
  always_comb begin
    cmd_go = (q.tog_s2 ^ q.tog_s3) && (q.pwr == PWR_RUN);
    pm = {q.ctl.nv.protect_mode_hi, q.ctl.nv.protect_mode_lo}; // RULE_15
    // quad mode hands the pin over to data, so it cannot protect
    wp_eff = q.ctl.nv.quad_enable | q.wp_s2; // RULE_11
    unique case (pm)
      PM_SOFTWARE: wsr_allowed = q.write_enable_latch; // RULE_16
      PM_HARDWARE: begin
        wsr_allowed = q.write_enable_latch && wp_eff; // RULE_01 RULE_17
      end
      PM_LOCKDOWN: wsr_allowed = 1'b0; // RULE_02
      PM_ONE_TIME: wsr_allowed = 1'b0; // RULE_04
    endcase
    // lock bits only ever gain ones
    new_locks = q.ctl.nv.secure_lock_bits
      | lq.cmd.data[BIT_LOCK_HI:BIT_LOCK_LO]; // RULE_08
    // four-wire mode pins quad enable at one
    new_quad = lq.cmd.data[BIT_QUAD] | q.four_wire; // RULE_13
    sec_locked = q.ctl.nv.secure_lock_bits[lq.cmd.sec_sel];
  end

  // next state: power sequence, synchronisers, command execution
  always_comb begin
    next_q = q;
    next_q.tog_s1 = lq.tog;
    next_q.tog_s2 = q.tog_s1;
    next_q.tog_s3 = q.tog_s2;
    next_q.wp_s1 = write_protect_n_i;
    next_q.wp_s2 = q.wp_s1;
    next_q.hold_s1 = hold_n_i;
    next_q.hold_s2 = q.hold_s1;
    next_q.wsr_done = 1'b0;
    next_q.wsr_refused = 1'b0;
    next_q.sec_grant = 1'b0;
    next_q.sec_refused = 1'b0;
    next_q.cmd_ignored = 1'b0;
    unique case (q.pwr)
      PWR_OFF: begin
        next_q.pwr = PWR_LOAD;
      end
      PWR_LOAD: begin
        // power-up: take the stored image, volatile bits start clear
        next_q.ctl.nv = nv_image_i; // RULE_07 RULE_10
        next_q.ctl.suspend_flag = 1'b0; // RULE_06
        if ({nv_image_i.protect_mode_hi, nv_image_i.protect_mode_lo}
            == PM_LOCKDOWN) begin
          next_q.ctl.nv.protect_mode_hi = PM_SOFTWARE[1]; // RULE_03
          next_q.ctl.nv.protect_mode_lo = PM_SOFTWARE[0]; // RULE_03
        end
        next_q.pwr = PWR_RUN;
        next_q.ready = 1'b1;
      end
      PWR_RUN: begin
        if (cmd_go) begin
          unique case (lq.cmd.opcode)
            OP_WRITE_ENABLE: next_q.write_enable_latch = 1'b1;
            OP_WRITE_DISABLE: next_q.write_enable_latch = 1'b0;
            OP_WRITE_STATUS: begin
              if (wsr_allowed) begin
                next_q.ctl.nv.secure_lock_bits = new_locks; // RULE_08
                next_q.ctl.nv.quad_enable = new_quad; // RULE_13
                next_q.ctl.nv.protect_mode_hi = lq.cmd.data[BIT_PM_HI];
                next_q.ctl.nv.protect_mode_lo = lq.cmd.data[BIT_PM_LO];
                next_q.write_enable_latch = 1'b0;
                next_q.wsr_done = 1'b1;
              end else begin
                // refused: nothing changes, latch included
                next_q.wsr_refused = 1'b1; // RULE_18
              end
            end
            OP_SUSPEND: next_q.ctl.suspend_flag = 1'b1; // RULE_05
            OP_RESUME: next_q.ctl.suspend_flag = 1'b0; // RULE_06
            OP_FOUR_WIRE_ON: begin
              if (q.ctl.nv.quad_enable) begin
                next_q.four_wire = 1'b1;
              end else begin
                next_q.cmd_ignored = 1'b1; // RULE_12
              end
            end
            OP_FOUR_WIRE_OFF: next_q.four_wire = 1'b0;
            OP_SEC_PROGRAM, OP_SEC_ERASE: begin
              if (sec_locked || !q.write_enable_latch) begin
                next_q.sec_refused = 1'b1; // RULE_09
              end else begin
                next_q.sec_grant = 1'b1;
                next_q.write_enable_latch = 1'b0;
              end
            end
            default: next_q.cmd_ignored = 1'b1;
          endcase
        end
      end
      default: next_q.pwr = PWR_OFF;
    endcase
    // pin functions follow the quad enable bit
    next_q.wp_func = ~next_q.ctl.nv.quad_enable; // RULE_10 RULE_11
    next_q.hold_func = ~next_q.ctl.nv.quad_enable; // RULE_10 RULE_11
    next_q.hold_held = ~next_q.ctl.nv.quad_enable & ~q.hold_s2;
    if (srst_i) begin
      // power down: volatile state cleared, image reloaded on release
      next_q = '0;
      next_q.pwr = PWR_OFF;
      next_q.ctl.nv.secure_lock_bits = LOCK_NONE;
      next_q.wp_func = 1'b1;
      next_q.hold_func = 1'b1;
      // pins idle high, so no false hold follows power-up
      next_q.wp_s1 = 1'b1;
      next_q.wp_s2 = 1'b1;
      next_q.hold_s1 = 1'b1;
      next_q.hold_s2 = 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    q <= next_q;
  end

  // outputs straight from the state flops
  assign ready_o = q.ready;
  assign ctl_o = q.ctl;
  assign write_enable_latch_o = q.write_enable_latch;
  assign four_wire_command_mode_o = q.four_wire;
  assign wp_function_o = q.wp_func;
  assign hold_function_o = q.hold_func;
  assign hold_asserted_o = q.hold_held;
  assign wsr_done_o = q.wsr_done;
  assign wsr_refused_o = q.wsr_refused;
  assign sec_grant_o = q.sec_grant;
  assign sec_refused_o = q.sec_refused;
  assign cmd_ignored_o = q.cmd_ignored;

  // ===========================================================
  // checks
  logic wsr_go;
  assign wsr_go = cmd_go && (lq.cmd.opcode == OP_WRITE_STATUS);

  property p_soft_write;
    @(posedge mclk_i) disable iff (srst_i)
    wsr_go && (pm == PM_SOFTWARE) && q.write_enable_latch |=> wsr_done_o
      && !q.write_enable_latch;
  endproperty
  a_soft_write: assert property (p_soft_write) // RULE_16
    else $error("software mode write with latch not done");

  property p_hw_needs_latch;
    @(posedge mclk_i) disable iff (srst_i)
    wsr_go && (pm == PM_HARDWARE) && !q.write_enable_latch
      |=> wsr_refused_o
      && $stable(ctl_o);
  endproperty
  a_hw_needs_latch: assert property (p_hw_needs_latch) // RULE_01
    else $error("hardware mode write taken without latch");

  property p_hw_pin_lock;
    @(posedge mclk_i) disable iff (srst_i)
    wsr_go && (pm == PM_HARDWARE) && !wp_eff |=> wsr_refused_o
      && !wsr_done_o;
  endproperty
  a_hw_pin_lock: assert property (p_hw_pin_lock) // RULE_17
    else $error("write taken with protect pin low");

  property p_lockdown;
    @(posedge mclk_i) disable iff (srst_i)
    wsr_go && (pm == PM_LOCKDOWN) |=> wsr_refused_o && $stable(ctl_o.nv);
  endproperty
  a_lockdown: assert property (p_lockdown) // RULE_02 RULE_18
    else $error("lock-down mode write changed status");

  property p_one_time;
    @(posedge mclk_i) disable iff (srst_i)
    (q.pwr == PWR_RUN) && (pm == PM_ONE_TIME) |=> ##[0:2]
      ({ctl_o.nv.protect_mode_hi, ctl_o.nv.protect_mode_lo} == PM_ONE_TIME);
  endproperty
  a_one_time: assert property (p_one_time) // RULE_04
    else $error("one-time protect mode left");

  property p_power_up_release;
    @(posedge mclk_i) disable iff (srst_i)
    (q.pwr == PWR_LOAD) |=> !ctl_o.suspend_flag && ready_o
      && ({ctl_o.nv.protect_mode_hi, ctl_o.nv.protect_mode_lo}
      != PM_LOCKDOWN);
  endproperty
  a_power_up_release: assert property (p_power_up_release) // RULE_03
    else $error("lock-down survived power cycle");

  property p_suspend;
    @(posedge mclk_i) disable iff (srst_i)
    cmd_go && (lq.cmd.opcode == OP_SUSPEND) |=> ctl_o.suspend_flag;
  endproperty
  a_suspend: assert property (p_suspend) // RULE_05
    else $error("suspend flag not set");

  property p_resume;
    @(posedge mclk_i) disable iff (srst_i)
    cmd_go && (lq.cmd.opcode == OP_RESUME) |=> !ctl_o.suspend_flag;
  endproperty
  a_resume: assert property (p_resume) // RULE_06
    else $error("suspend flag not cleared");

  property p_lock_sticky;
    @(posedge mclk_i) disable iff (srst_i)
    (q.pwr == PWR_RUN) |=> ((ctl_o.nv.secure_lock_bits
      & $past(ctl_o.nv.secure_lock_bits))
      == $past(ctl_o.nv.secure_lock_bits));
  endproperty
  a_lock_sticky: assert property (p_lock_sticky) // RULE_08
    else $error("lock bit returned to zero");

  property p_sec_locked;
    @(posedge mclk_i) disable iff (srst_i)
    cmd_go && sec_locked && ((lq.cmd.opcode == OP_SEC_PROGRAM)
      || (lq.cmd.opcode == OP_SEC_ERASE)) |=> sec_refused_o && !sec_grant_o;
  endproperty
  a_sec_locked: assert property (p_sec_locked) // RULE_09
    else $error("locked security register altered");

  property p_pins_follow_quad;
    @(posedge mclk_i) disable iff (srst_i)
    $rose(ctl_o.nv.quad_enable) |-> !wp_function_o && !hold_function_o
      && !hold_asserted_o;
  endproperty
  a_pins_follow_quad: assert property (p_pins_follow_quad) // RULE_11
    else $error("pin functions active in quad mode");

  property p_four_wire_gate;
    @(posedge mclk_i) disable iff (srst_i)
    cmd_go && (lq.cmd.opcode == OP_FOUR_WIRE_ON) && !q.ctl.nv.quad_enable
      && !q.four_wire |=> !four_wire_command_mode_o && cmd_ignored_o;
  endproperty
  a_four_wire_gate: assert property (p_four_wire_gate) // RULE_12
    else $error("four-wire mode entered without quad enable");

  property p_four_wire_quad;
    @(posedge mclk_i) disable iff (srst_i)
    four_wire_command_mode_o |-> ctl_o.nv.quad_enable;
  endproperty
  a_four_wire_quad: assert property (p_four_wire_quad) // RULE_13
    else $error("quad enable cleared in four-wire mode");

  property p_otp_refuse;
    @(posedge mclk_i) disable iff (srst_i)
    wsr_go && (pm == PM_ONE_TIME) |=> wsr_refused_o && $stable(ctl_o)
      && $stable(write_enable_latch_o);
  endproperty
  a_otp_refuse: assert property (p_otp_refuse) // RULE_04 RULE_18
    else $error("one-time mode write not refused intact");

  property p_soft_needs_latch;
    @(posedge mclk_i) disable iff (srst_i)
    wsr_go && (pm == PM_SOFTWARE) && !q.write_enable_latch
      |=> wsr_refused_o && $stable(ctl_o);
  endproperty
  a_soft_needs_latch: assert property (p_soft_needs_latch) // RULE_16
    else $error("software mode write taken without latch");

  property p_hold_active;
    @(posedge mclk_i) disable iff (srst_i)
    (q.pwr == PWR_RUN) && !cmd_go && !ctl_o.nv.quad_enable && !q.hold_s2
      |=> hold_asserted_o;
  endproperty
  a_hold_active: assert property (p_hold_active) // RULE_10
    else $error("hold pin low but hold not signalled");

endmodule // status_protection_control

// File: host_model.sv
// host side of the serial command link: framed commands on a link clock.
// assumes the block samples strobe and command on rising link clock edges.
module host_model
  import spc_pkg::*;
(
  output logic sclk_o,
  output logic strobe_o,
  output cmd_t cmd_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================
  // idle link: clock stands still, strobe low
  initial begin
    sclk_o = 1'b0;
    strobe_o = 1'b0;
    cmd_o = '0;
  end

  // bare clock ticks so the link side sees a reset
  task automatic ticks(input int n);
    repeat (n) begin
      #40 sclk_o = 1'b1;
      #40 sclk_o = 1'b0;
    end
  endtask

  // one byte frame; command set on edge 7, held through edge 8
  task automatic send(input cmd_t c);
    for (int i = 0; i < 8; i++) begin
      #40 sclk_o = 1'b1;
      if (i == 6) begin
        strobe_o <= 1'b1;
        cmd_o <= c;
      end else if (i == 7) begin
        strobe_o <= 1'b0;
        cmd_o <= ~c; // released lines show no stale value
      end
      #40 sclk_o = 1'b0;
    end
  endtask
endmodule // host_model

// File: tb.sv
// self-checking bench for the status protection control block.
// assumes host_model as link partner and the bench as non-volatile store.
module tb
  import spc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic mclk_i = 1'b0, srst_i = 1'b1, wp_n = 1'b1, hold_n = 1'b1;
  logic sclk, strobe, ready, latch, fw, wpf, hf, ha, done, wref, grant;
  logic sref, ign;
  logic [3:0] pexp = 4'h6;
  cmd_t cmd;
  nv_t img = '0;
  ctl_bits_t ctl;
  int n_errors = 0, checks = 0, cyc = 0;

  // system clock
  always #4 mclk_i = ~mclk_i;

  host_model host_model_i (.sclk_o(sclk), .strobe_o(strobe), .cmd_o(cmd));
  status_protection_control status_protection_control_i (
    .mclk_i(mclk_i), .srst_i(srst_i), .sclk_i(sclk), .cmd_strobe_i(strobe),
    .cmd_i(cmd), .write_protect_n_i(wp_n), .hold_n_i(hold_n),
    .nv_image_i(img), .ready_o(ready), .ctl_o(ctl),
    .write_enable_latch_o(latch), .four_wire_command_mode_o(fw),
    .wp_function_o(wpf), .hold_function_o(hf), .hold_asserted_o(ha),
    .wsr_done_o(done), .wsr_refused_o(wref), .sec_grant_o(grant),
    .sec_refused_o(sref), .cmd_ignored_o(ign));

  // ==========================================================
  // checking and closing
  task automatic check(input string nm, input logic [17:0] seen,
                       input logic [17:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic finish_test();
    if (n_errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 10000) begin
      n_errors++;
      finish_test();
    end
  end

  // ==========================================================
  // drivers
  task automatic power(input nv_t image, input logic [7:0] c);
    @(posedge mclk_i) begin
      srst_i <= 1'b1;
      img <= image;
    end
    fork
      repeat (12) @(posedge mclk_i);
      host_model_i.ticks(4);
    join
    @(posedge mclk_i) srst_i <= 1'b0;
    for (int i = 0; i < 10 && ready !== 1'b1; i++) begin
      @(posedge mclk_i) #1;
    end
    @(posedge mclk_i) #1;
    check("power", {4'h0, ready, latch, fw, wpf, hf, ha, ctl},
          {5'h01, 1'b0, pexp, c});
  endtask

  // one command; pulses gathered while the frame runs
  task automatic run(input logic [7:0] op, input logic [15:0] d,
                     input logic [1:0] s, input logic [4:0] r,
                     input logic w, input logic [7:0] c);
    logic [4:0] res;
    res = '0;
    fork
      host_model_i.send({op, d, s});
      repeat (90) @(posedge mclk_i) #1 res |= {done, wref, grant, sref, ign};
    join
    check("result", {res, latch, fw, wpf, hf, ha, ctl}, {r, w, pexp, c});
  endtask

  task automatic wen(input logic [7:0] c);
    run(OP_WRITE_ENABLE, 16'h0000, 2'h0, 5'h00, 1'b1, c);
  endtask

  task automatic wsr(input logic [15:0] d, input logic [4:0] r,
                     input logic w, input logic [7:0] c);
    run(OP_WRITE_STATUS, d, 2'h0, r, w, c);
  endtask

  // pins are driven, never tied to the rails
  task automatic pins(input logic wp, input logic hold, input logic [3:0] p);
    @(posedge mclk_i) begin
      wp_n <= wp;
      hold_n <= hold;
    end
    repeat (6) @(posedge mclk_i);
    pexp = p;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_software();
    wsr(16'h0080, 5'h08, 1'b0, 8'h00);
    wen(8'h00);
    pins(1'b0, 1'b1, 4'h6);
    wsr(16'h0080, 5'h10, 1'b0, 8'h01);
  endtask

  task automatic t_hardware();
    wen(8'h01);
    wsr(16'h0000, 5'h08, 1'b1, 8'h01);
    pins(1'b1, 1'b1, 4'h6);
    run(OP_WRITE_DISABLE, 16'h0000, 2'h0, 5'h00, 1'b0, 8'h01);
    wsr(16'h0000, 5'h08, 1'b0, 8'h01);
    wen(8'h01);
    wsr(16'h0100, 5'h10, 1'b0, 8'h02);
  endtask

  task automatic t_lockdown();
    wen(8'h02);
    wsr(16'h0000, 5'h08, 1'b1, 8'h02);
    power(7'h02, 8'h00);
  endtask

  task automatic t_otp();
    power(7'h03, 8'h03);
    wen(8'h03);
    wsr(16'h0000, 5'h08, 1'b1, 8'h03);
    pins(1'b0, 1'b1, 4'h6);
    wsr(16'h0000, 5'h08, 1'b1, 8'h03);
    pins(1'b1, 1'b1, 4'h6);
  endtask

  task automatic t_suspend();
    power(7'h00, 8'h00);
    run(OP_SUSPEND, 16'h0000, 2'h0, 5'h00, 1'b0, 8'h80);
    wen(8'h80);
    wsr(16'h0000, 5'h10, 1'b0, 8'h80);
    run(OP_RESUME, 16'h0000, 2'h0, 5'h00, 1'b0, 8'h00);
    wen(8'h00);
    wsr(16'h8000, 5'h10, 1'b0, 8'h00);
    run(OP_SUSPEND, 16'h0000, 2'h0, 5'h00, 1'b0, 8'h80);
    power(7'h00, 8'h00);
  endtask

  task automatic t_locks();
    wen(8'h00);
    wsr(16'h0800, 5'h10, 1'b0, 8'h10);
    wen(8'h10);
    wsr(16'h2000, 5'h10, 1'b0, 8'h50);
    wen(8'h50);
    run(OP_SEC_PROGRAM, 16'h0000, 2'h1, 5'h02, 1'b1, 8'h50);
    run(OP_SEC_ERASE, 16'h0000, 2'h3, 5'h02, 1'b1, 8'h50);
    run(OP_SEC_ERASE, 16'h0000, 2'h0, 5'h04, 1'b0, 8'h50);
    power(7'h50, 8'h50);
  endtask

  task automatic t_quad();
    pins(1'b1, 1'b0, 4'h7);
    run(OP_FOUR_WIRE_ON, 16'h0000, 2'h0, 5'h01, 1'b0, 8'h50);
    run(8'h5A, 16'h0000, 2'h0, 5'h01, 1'b0, 8'h50);
    wen(8'h50);
    pexp = 4'h0;
    wsr(16'h0200, 5'h10, 1'b0, 8'h54);
    pexp = 4'h8;
    run(OP_FOUR_WIRE_ON, 16'h0000, 2'h0, 5'h00, 1'b0, 8'h54);
    wen(8'h54);
    wsr(16'h0000, 5'h10, 1'b0, 8'h54);
    pexp = 4'h0;
    run(OP_FOUR_WIRE_OFF, 16'h0000, 2'h0, 5'h00, 1'b0, 8'h54);
  endtask

  // main sequence
  initial begin
    power(7'h00, 8'h00);
    t_software();
    t_hardware();
    t_lockdown();
    t_otp();
    t_suspend();
    t_locks();
    t_quad();
    finish_test();
  end
endmodule // tb
